/* rtl/crs_pkg.sv */
package crs_pkg;

  // ************************************************************
  // clock and ramp scaling
  // ************************************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  // one rate unit is 1 us per kHz, i.e. 1e9 Hz/s divided by the value
  localparam int unsigned RATE_UNIT_HZ_PER_S = 1_000_000_000;
  localparam int unsigned RATE_STEP_NUM = RATE_UNIT_HZ_PER_S / CLK_HZ;
  // one time unit is 1 ms
  localparam int unsigned TIME_UNIT_PER_S = 1000;
  localparam int unsigned TIME_DEN_SCALE = CLK_HZ / TIME_UNIT_PER_S;

  // ************************************************************
  // value ranges and reset values
  // ************************************************************
  localparam int unsigned VAL_W = 20;
  localparam logic [19:0] VAL_MIN = 20'h0_0001;
  localparam logic [19:0] VAL_MAX = 20'hF_4240;
  localparam logic [19:0] VAL_RST = 20'h0_03E8;
  localparam logic [19:0] START_SPEED_RST = 20'h0_01F4;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_START_SPEED = 12'h004;
  localparam logic [11:0] ADDR_SHARED_ACCEL = 12'h008;
  localparam logic [11:0] ADDR_SHARED_DECEL = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_SPEED = 12'h014;
  localparam logic [3:0] PAGE_RUN_SPEED = 4'h1;
  localparam logic [3:0] PAGE_ACCEL = 4'h2;
  localparam logic [3:0] PAGE_DECEL = 4'h3;

  localparam int unsigned CTRL_COMMON_BIT = 0;
  localparam int unsigned CTRL_TIME_BIT = 1;
  localparam int unsigned STAT_READY_BIT = 0;
  localparam int unsigned STAT_MOVE_BIT = 1;
  localparam int unsigned STAT_DIR_BIT = 2;
  localparam int unsigned STAT_HALT_BIT = 3;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_DECEL = 4'b0100,
    ST_HALT  = 4'b1000
  } crs_state_t;

endpackage

/* rtl/crs_continuous_run.sv */
`timescale 1ns/100ps
module crs_continuous_run
  import crs_pkg::*;
#(
  parameter int unsigned ENTRIES = 64,
  parameter int unsigned ACC_W = 40
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // run and selector inputs
  input wire logic forward_run_in,
  input wire logic reverse_run_in,
  input wire logic data_select_bit0,
  input wire logic data_select_bit1,
  input wire logic data_select_bit2,
  input wire logic data_select_bit3,
  input wire logic data_select_bit4,
  input wire logic data_select_bit5,
  // status and motion outputs
  output logic ready_out,
  output logic move_out,
  output logic dir_fwd_out,
  output logic step_out,
  output logic [19:0] speed_out
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (ENTRIES != 64) begin : g_bad_entries
    $error("ENTRIES must be 64 for a six bit selector");
  end
  if (ACC_W < 38) begin : g_bad_acc
    $error("ACC_W too narrow for time mode denominator");
  end

  // ************************************************************
  // registers and table
  // ************************************************************
  logic [19:0] spd_tab [ENTRIES];
  logic [19:0] acc_tab [ENTRIES];
  logic [19:0] dec_tab [ENTRIES];
  logic ramp_common_r;
  logic ramp_time_r;
  logic [19:0] start_speed_r;
  logic [19:0] shared_accel_r;
  logic [19:0] shared_decel_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  crs_state_t state_r;
  crs_state_t state_nxt;
  logic [19:0] speed_r;
  logic [19:0] speed_nxt;
  logic dir_r;
  logic dir_nxt;
  logic acc_clr;
  logic [ACC_W-1:0] ramp_acc_r;
  logic ready_r;
  logic move_r;
  logic step_r;
  logic [26:0] phase_r;

  // ************************************************************
  // apb decode
  // ************************************************************
  logic setup_ph;
  logic wr_en;
  logic in_table;
  logic mapped;
  logic [5:0] widx;
  logic [19:0] wval;
  logic [19:0] wval_start;

  assign setup_ph = psel & ~penable;
  assign widx = paddr[7:2];
  assign in_table = (paddr[11:8] == PAGE_RUN_SPEED) |
                    (paddr[11:8] == PAGE_ACCEL) |
                    (paddr[11:8] == PAGE_DECEL);
  assign mapped = (paddr[1:0] == 2'b00) &
                  (in_table | (paddr == ADDR_CTRL) |
                   (paddr == ADDR_START_SPEED) |
                   (paddr == ADDR_SHARED_ACCEL) |
                   (paddr == ADDR_SHARED_DECEL) |
                   (paddr == ADDR_STATUS) | (paddr == ADDR_SPEED));
  assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;
  // out-of-range writes saturate rather than fault
  assign wval = (pwdata == 32'h0000_0000) ? VAL_MIN :
                (pwdata > {12'h000, VAL_MAX}) ? VAL_MAX : pwdata[19:0];
  assign wval_start = (pwdata > {12'h000, VAL_MAX}) ? VAL_MAX :
                      pwdata[19:0];

  // read data is captured in setup, so pready can rise in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_ph;
      if (setup_ph) begin
        pslverr_r <= ~mapped;
        prdata_r <= 32'h0000_0000;
        if (mapped && !pwrite) begin
          case (paddr[11:8])
            PAGE_RUN_SPEED: prdata_r <= {12'h000, spd_tab[widx]};
            PAGE_ACCEL: prdata_r <= {12'h000, acc_tab[widx]};
            PAGE_DECEL: prdata_r <= {12'h000, dec_tab[widx]};
            default: begin
              case (paddr)
                ADDR_CTRL: prdata_r <= {30'h0000_0000, ramp_time_r,
                                        ramp_common_r};
                ADDR_START_SPEED: prdata_r <= {12'h000, start_speed_r};
                ADDR_SHARED_ACCEL: prdata_r <= {12'h000, shared_accel_r};
                ADDR_SHARED_DECEL: prdata_r <= {12'h000, shared_decel_r};
                ADDR_STATUS: prdata_r <= {28'h000_0000,
                                          state_r == ST_HALT, dir_r,
                                          move_r, ready_r};
                ADDR_SPEED: prdata_r <= {12'h000, speed_r};
                default: prdata_r <= 32'h0000_0000;
              endcase
            end
          endcase
        end
      end
    end
  end

  // ************************************************************
  // configuration writes
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_common_r <= 1'b0;
      ramp_time_r <= 1'b0;
      start_speed_r <= START_SPEED_RST;
      shared_accel_r <= VAL_RST;
      shared_decel_r <= VAL_RST;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: begin
          ramp_common_r <= pwdata[CTRL_COMMON_BIT];
          ramp_time_r <= pwdata[CTRL_TIME_BIT];
        end
        ADDR_START_SPEED: start_speed_r <= wval_start;
        ADDR_SHARED_ACCEL: shared_accel_r <= wval;
        ADDR_SHARED_DECEL: shared_decel_r <= wval;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ENTRIES; i++) begin
        spd_tab[i] <= VAL_RST;
        acc_tab[i] <= VAL_RST;
        dec_tab[i] <= VAL_RST;
      end
    end else if (wr_en) begin
      case (paddr[11:8])
        PAGE_RUN_SPEED: spd_tab[widx] <= wval;
        PAGE_ACCEL: acc_tab[widx] <= wval;
        PAGE_DECEL: dec_tab[widx] <= wval;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // entry selection and ramp rate
  // ************************************************************
  logic [5:0] sel;
  logic [19:0] target;
  logic [19:0] accel_v;
  logic [19:0] decel_v;
  logic ramp_dn;
  logic [19:0] ramp_v;
  logic [ACC_W-1:0] den;
  logic [ACC_W-1:0] num;
  logic [ACC_W-1:0] acc_sum;
  logic tick;

  // sampled every cycle, so selector and run may change together
  assign sel = {data_select_bit5, data_select_bit4, data_select_bit3,
                data_select_bit2, data_select_bit1,
                data_select_bit0};
  assign target = spd_tab[sel];
  assign accel_v = ramp_common_r ? shared_accel_r : acc_tab[sel];
  assign decel_v = ramp_common_r ? shared_decel_r : dec_tab[sel];
  assign ramp_dn = (state_r == ST_DECEL) | (speed_r > target);
  assign ramp_v = ramp_dn ? decel_v : accel_v;
  // in time mode rate = (run - start) / time, done as a fraction to avoid a divider
  assign den = ramp_time_r ?
               ACC_W'(ramp_v) * ACC_W'(TIME_DEN_SCALE) :
               ACC_W'(ramp_v);
  assign num = !ramp_time_r ? ACC_W'(RATE_STEP_NUM) :
               (target > start_speed_r) ?
               ACC_W'(target - start_speed_r) :
               ACC_W'(1);
  assign acc_sum = ramp_acc_r + num;
  // limitation: at most 1 Hz per clock, i.e. 125 MHz/s
  assign tick = acc_sum >= den;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_acc_r <= '0;
    end else if (acc_clr) begin
      ramp_acc_r <= '0;
    end else if (tick) begin
      ramp_acc_r <= (acc_sum - den < den) ? acc_sum - den : '0;
    end else begin
      ramp_acc_r <= acc_sum;
    end
  end

  // ************************************************************
  // run sequencer
  // ************************************************************
  logic fwd_only;
  logic rvs_only;
  logic both_on;
  logic same_only;
  logic opp_only;

  assign fwd_only = forward_run_in & ~reverse_run_in;
  assign rvs_only = reverse_run_in & ~forward_run_in;
  assign both_on = forward_run_in & reverse_run_in;
  assign same_only = dir_r ? fwd_only : rvs_only;
  assign opp_only = dir_r ? rvs_only : fwd_only;

  always_comb begin
    state_nxt = state_r;
    speed_nxt = speed_r;
    dir_nxt = dir_r;
    acc_clr = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (fwd_only || rvs_only) begin
          state_nxt = ST_RUN;
          dir_nxt = fwd_only;
          speed_nxt = start_speed_r;
          acc_clr = 1'b1;
        end
      end
      ST_RUN: begin
        if (!same_only) begin
          state_nxt = ST_DECEL;
          acc_clr = 1'b1;
        end else if (tick && speed_r < target) begin
          speed_nxt = speed_r + 20'h0_0001;
        end else if (tick && speed_r > target) begin
          speed_nxt = speed_r - 20'h0_0001;
        end
      end
      ST_DECEL: begin
        if (same_only) begin
          state_nxt = ST_RUN;
          acc_clr = 1'b1;
        end else if (speed_r <= start_speed_r ||
                     speed_r == 20'h0_0000) begin
          speed_nxt = 20'h0_0000;
          acc_clr = 1'b1;
          if (both_on) begin
            state_nxt = ST_HALT;
          end else if (opp_only) begin
            state_nxt = ST_RUN;
            dir_nxt = ~dir_r;
            speed_nxt = start_speed_r;
          end else begin
            state_nxt = ST_IDLE;
          end
        end else if (tick) begin
          speed_nxt = speed_r - 20'h0_0001;
        end
      end
      ST_HALT: begin
        if (!forward_run_in && !reverse_run_in) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      speed_r <= 20'h0_0000;
      dir_r <= 1'b1;
      ready_r <= 1'b1;
      move_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      speed_r <= speed_nxt;
      dir_r <= dir_nxt;
      ready_r <= (state_nxt == ST_IDLE);
      move_r <= (state_nxt == ST_RUN) |
                (state_nxt == ST_DECEL);
    end
  end

  // ************************************************************
  // step pulse generator
  // ************************************************************
  logic [27:0] phase_sum;
  assign phase_sum = {1'b0, phase_r} + {8'h00, speed_r};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 27'h000_0000;
      step_r <= 1'b0;
    end else if (!move_r) begin
      phase_r <= 27'h000_0000;
      step_r <= 1'b0;
    end else if (phase_sum >= 28'(CLK_HZ)) begin
      phase_r <= 27'(phase_sum - 28'(CLK_HZ));
      step_r <= 1'b1;
    end else begin
      phase_r <= phase_sum[26:0];
      step_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign ready_out = ready_r;
  assign move_out = move_r;
  assign dir_fwd_out = dir_r;
  assign step_out = step_r;
  assign speed_out = speed_r;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  run_keeps_move_a: assert property ((state_r == ST_RUN) && same_only
    |=> move_r && (dir_r == $past(dir_r)))
    else $error("run dropped while run input held");
  hold_target_a: assert property ((state_r == ST_RUN) && same_only &&
    (speed_r == target) && $stable(target) |=> speed_r == $past(speed_r))
    else $error("speed left target while steady");
  seek_target_a: assert property ((state_r == ST_RUN) && same_only &&
    (speed_r < target) |=> speed_r >= $past(speed_r))
    else $error("speed fell while below target");
  release_decel_a: assert property ((state_r == ST_RUN) &&
    !forward_run_in && !reverse_run_in |=> state_r == ST_DECEL)
    else $error("release did not start deceleration");
  both_decel_a: assert property (both_on |=> state_r != ST_RUN)
    else $error("running with both inputs on");
  speed_range_a: assert property (speed_r <= VAL_MAX)
    else $error("speed above maximum");
  ready_drop_a: assert property ($rose(move_r) |-> !ready_r)
    else $error("ready high while moving");
  halt_flags_a: assert property ((state_r == ST_HALT) && both_on
    |=> !move_r && !ready_r)
    else $error("halt shows motion or ready");
  ready_rise_a: assert property ($rose(ready_r)
    |-> $past(!forward_run_in && !reverse_run_in) && speed_r == 0)
    else $error("ready rose with input held or motor moving");
  reverse_start_a: assert property ((state_r == ST_DECEL) && opp_only &&
    (speed_r <= start_speed_r) |=> (state_r == ST_RUN) &&
    (dir_r != $past(dir_r)) && (speed_r == $past(start_speed_r)))
    else $error("reversal did not restart from start speed");
  linear_step_a: assert property ((state_r == ST_RUN) &&
    ($past(state_r) == ST_RUN) |-> (speed_r - $past(speed_r) <= 20'h0_0001)
    || ($past(speed_r) - speed_r <= 20'h0_0001))
    else $error("speed jumped more than one step");

  reaccel_c: cover property ((state_r == ST_DECEL) ##1 (state_r == ST_RUN));
  reverse_c: cover property ((state_r == ST_RUN) && (dir_r != $past(dir_r)));
  halt_c: cover property ((state_r == ST_HALT) ##1 (state_r == ST_IDLE));
  step_c: cover property (step_r && (speed_r == target));

endmodule // crs_continuous_run

/* verification/crs_host_model.sv */
`timescale 1ns/100ps
module crs_host_model
  import crs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the test sequence
  input wire logic cmd_fwd,
  input wire logic cmd_rev,
  input wire logic [5:0] cmd_sel,
  // status seen from the device
  input wire logic ready_out,
  input wire logic move_out,
  // run and selector lines
  output logic forward_run_in,
  output logic reverse_run_in,
  output logic [5:0] data_select
);
  // ************************************************************
  // host side of the run handshake
  // ************************************************************
  logic starting;

  // a start from standstill is gated; releases and mid-motion changes pass
  assign starting = !forward_run_in && !reverse_run_in && !move_out &&
                    (cmd_fwd || cmd_rev);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forward_run_in <= 1'b0;
      reverse_run_in <= 1'b0;
      data_select <= 6'h00;
    end else begin
      data_select <= cmd_sel;
      // wait for ready, and let the selector settle one cycle first
      if (!starting || (ready_out && data_select == cmd_sel)) begin
        forward_run_in <= cmd_fwd;
        reverse_run_in <= cmd_rev;
      end
    end
  end
endmodule // crs_host_model

/* verification/crs_continuous_run_bench.sv */
`timescale 1ns/100ps
module crs_continuous_run_bench
  import crs_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cmd_fwd, cmd_rev, fwd_w, rev_w;
  logic [5:0] cmd_sel, sel_w;
  logic ready_out, move_out, dir_fwd_out, step_out;
  logic [19:0] speed_out;
  int error_cnt = 0;
  int n_compared = 0;
  int step_cnt = 0;
  int steps0;
  // selector values touching every bit, and their run speeds
  localparam logic [5:0] SEL[8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08,
                                    6'h10, 6'h20, 6'h3F};
  localparam logic [19:0] SPD[8] = '{20'h0_03E8, 20'h0_03FC, 20'h0_0410,
    20'h0_0424, 20'h0_0438, 20'h0_044C, 20'h0_0460, 20'h0_0474};

  crs_continuous_run crs_continuous_run_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .forward_run_in(fwd_w), .reverse_run_in(rev_w),
    .data_select_bit0(sel_w[0]), .data_select_bit1(sel_w[1]),
    .data_select_bit2(sel_w[2]), .data_select_bit3(sel_w[3]),
    .data_select_bit4(sel_w[4]), .data_select_bit5(sel_w[5]),
    .ready_out(ready_out), .move_out(move_out),
    .dir_fwd_out(dir_fwd_out), .step_out(step_out), .speed_out(speed_out));

  crs_host_model crs_host_model_inst (
    .pclk(pclk), .presetn(presetn), .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev),
    .cmd_sel(cmd_sel), .ready_out(ready_out), .move_out(move_out),
    .forward_run_in(fwd_w), .reverse_run_in(rev_w), .data_select(sel_w));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check("prdata", rd, exp);
    check("pslverr", {31'h0, err}, {31'h0, experr});
  endtask

  task automatic set_cmd(input logic f, input logic r, input logic [5:0] s);
    @(posedge pclk);
    cmd_fwd <= f;
    cmd_rev <= r;
    cmd_sel <= s;
  endtask

  function automatic logic [19:0] pick(input int what);
    case (what)
      0: return speed_out;
      1: return {19'h0, move_out};
      2: return {19'h0, ready_out};
      default: return {19'h0, dir_fwd_out};
    endcase
  endfunction

  // bounded wait for speed, move, ready or direction to reach a value
  task automatic wait_for(input int what, input logic [19:0] v);
    string nm[4] = '{"speed", "move", "ready", "dir"};
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (pick(what) !== v && n < 5000);
    check(nm[what], {12'h0, pick(what)}, {12'h0, v});
  endtask

  // ************************************************************
  // clock, reset, watchdog
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // step pulses seen so far, for the step rate check
  always @(posedge pclk) begin
    if (step_out === 1'b1) begin
      step_cnt <= step_cnt + 1;
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    summarize();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, cmd_fwd, cmd_rev} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cmd_sel = 6'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check("ready", {31'h0, ready_out}, 32'h0000_0001);
    check("move", {31'h0, move_out}, 32'h0000_0000);
    rd_chk(12'h1FC, 32'h0000_03E8, 1'b0);
    rd_chk(12'h200, 32'h0000_03E8, 1'b0);
    rd_chk(12'h3FC, 32'h0000_03E8, 1'b0);
    rd_chk(ADDR_SHARED_ACCEL, 32'h0000_03E8, 1'b0);
    rd_chk(12'hFF0, 32'h0000_0000, 1'b1);
    wr(12'h104, 32'h0000_0000);
    rd_chk(12'h104, 32'h0000_0001, 1'b0);
    wr(12'h104, 32'h000F_FFFF);
    rd_chk(12'h104, 32'h000F_4240, 1'b0);
    wr(12'h208, 32'h0000_0000);
    rd_chk(12'h208, 32'h0000_0001, 1'b0);
    // fast 1 Hz per clock ramps keep the run short
    wr(ADDR_START_SPEED, 32'h0000_0384);
    for (int i = 0; i < 8; i++) begin
      wr(12'h100 + {4'h0, SEL[i], 2'b00}, {12'h000, SPD[i]});
      wr(12'h200 + {4'h0, SEL[i], 2'b00}, 32'h0000_0001);
      wr(12'h300 + {4'h0, SEL[i], 2'b00}, 32'h0000_0001);
    end
    // forward run, every selector bit in turn
    set_cmd(1'b1, 1'b0, SEL[0]);
    wait_for(1, 20'h0_0001);
    check("speed", {12'h0, speed_out}, 32'h0000_0384);
    check("ready", {31'h0, ready_out}, 32'h0000_0000);
    check("dir", {31'h0, dir_fwd_out}, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    check("ramp", {31'h0, speed_out >= 20'h0_03A2}, 32'h0000_0001);
    wait_for(0, SPD[0]);
    for (int i = 1; i < 8; i++) begin
      set_cmd(1'b1, 1'b0, SEL[i]);
      wait_for(0, SPD[i]);
    end
    repeat (30) @(posedge pclk);
    check("hold", {12'h0, speed_out}, {12'h0, SPD[7]});
    // release, then reassert the same direction mid deceleration
    set_cmd(1'b0, 1'b0, SEL[7]);
    wait_for(0, 20'h0_044C);
    check("move", {31'h0, move_out}, 32'h0000_0001);
    set_cmd(1'b1, 1'b0, SEL[7]);
    wait_for(0, SPD[7]);
    // release, then the opposite direction mid deceleration
    set_cmd(1'b0, 1'b0, SEL[7]);
    wait_for(0, 20'h0_041A);
    set_cmd(1'b0, 1'b1, SEL[7]);
    wait_for(3, 20'h0_0000);
    wait_for(0, SPD[7]);
    check("move", {31'h0, move_out}, 32'h0000_0001);
    // both inputs on: stop, ready held off until both drop
    set_cmd(1'b1, 1'b1, SEL[7]);
    wait_for(1, 20'h0_0000);
    check("speed", {12'h0, speed_out}, 32'h0000_0000);
    repeat (8) @(posedge pclk);
    check("ready", {31'h0, ready_out}, 32'h0000_0000);
    rd_chk(ADDR_STATUS, 32'h0000_0008, 1'b0);
    set_cmd(1'b0, 1'b0, SEL[0]);
    wait_for(2, 20'h0_0001);
    // plain run and release back to ready
    set_cmd(1'b1, 1'b0, SEL[0]);
    wait_for(0, SPD[0]);
    set_cmd(1'b0, 1'b0, SEL[0]);
    wait_for(2, 20'h0_0001);
    check("speed", {12'h0, speed_out}, 32'h0000_0000);
    // common ramps: slow shared accel overrides the fast entry accel
    wr(ADDR_CTRL, 32'h0000_0001);
    set_cmd(1'b1, 1'b0, SEL[0]);
    wait_for(1, 20'h0_0001);
    repeat (100) @(posedge pclk);
    check("ramp", {31'h0, speed_out <= 20'h0_0385}, 32'h0000_0001);
    set_cmd(1'b0, 1'b0, SEL[0]);
    wait_for(2, 20'h0_0001);
    // time units: one unit of entry accel means a ramp over 1 ms
    wr(ADDR_CTRL, 32'h0000_0002);
    set_cmd(1'b1, 1'b0, SEL[0]);
    wait_for(1, 20'h0_0001);
    repeat (200) @(posedge pclk);
    check("ramp", {31'h0, speed_out <= 20'h0_0385}, 32'h0000_0001);
    set_cmd(1'b0, 1'b0, SEL[0]);
    wait_for(2, 20'h0_0001);
    // common time ramps: shared 1000 units outlasts the entry's 1 unit
    wr(ADDR_CTRL, 32'h0000_0003);
    set_cmd(1'b1, 1'b0, SEL[0]);
    wait_for(1, 20'h0_0001);
    repeat (1300) @(posedge pclk);
    check("ramp", {12'h0, speed_out}, 32'h0000_0384);
    set_cmd(1'b0, 1'b0, SEL[0]);
    wait_for(2, 20'h0_0001);
    // top speed from standstill: one step per CLK_HZ/1e6 clocks
    wr(ADDR_START_SPEED, 32'h000F_4240);
    wr(12'h100, 32'h000F_4240);
    set_cmd(1'b1, 1'b0, SEL[0]);
    wait_for(1, 20'h0_0001);
    rd_chk(ADDR_STATUS, 32'h0000_0006, 1'b0);
    rd_chk(ADDR_SPEED, 32'h000F_4240, 1'b0);
    steps0 = step_cnt;
    repeat (1250) @(posedge pclk);
    check("steps", step_cnt - steps0,
          32'(1250 / (CLK_HZ / 1_000_000)));
    set_cmd(1'b0, 1'b0, SEL[0]);
    wait_for(2, 20'h0_0001);
    summarize();
  end
endmodule // crs_continuous_run_bench
